/* bank_cmd_pkg.sv */
// Notes on behaviour
// R01: clock enable action uses previous and current level
// R02: enable low idle enters standby, reading suspends
// R03: standby exits on enable high with nop
// R04: suspend exit resumes, next command following edge
// R05: inhibit, nop, activate, read, write decoding
// R06: load command, load mode, terminate encodings
// R07: inhibit and nop start nothing new
// R08: idle bank accepts activate, loads, terminate
// R09: open row accepts read, write, terminate, load
// R10: reading bank accepts read, terminates, load command
// R11: writing bank accepts only read, load command
// R12: read during program returns previously open row
// R13: no command to terminating or activating bank; an active terminate to a terminating bank is accepted, not flagged
// R14: active terminate lasts one cycle then idle
// R15: activation lasts row to column delay
// R16: mode register access only nops, then idle
// R17: initialization after reset pin rise, 100us
// R18: load mode only when all banks idle
// R19: burst terminate ends most recent read burst; flagged illegal when that read went to a writing bank
// R20: other banks accept commands legal for them
// R21: idle bank does not restrict other banks
// R22: unlisted combinations are illegal, never produced
// R23: address bit 10 terminates all, else selected bank
// R24: suspended edges ignore inputs, freeze counters
package bank_cmd_pkg;
	localparam int NUM_BANKS        = 4;
	localparam int BANK_W           = 2;
	localparam int ROW_W            = 12;
	localparam int CLK_PERIOD_PS    = 25000;
	localparam int INIT_TIME_US     = 100;
	localparam int INIT_CYCLES      = (INIT_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RCD_CYCLES       = 3;
	localparam int MRD_CYCLES       = 2;
	localparam int TERM_ALL_BIT     = 10;
	localparam int WRITE_DONE_CYCLES = 16;

	typedef enum logic [3:0] {
		cmd_inhibit, cmd_nop, cmd_active, cmd_read, cmd_write,
		cmd_load_command, cmd_load_mode, cmd_active_terminate, cmd_burst_terminate,
		cmd_reserved
	} cmd_t;

	typedef enum logic [2:0] {
		bank_idle, bank_activating, bank_row_active, bank_read, bank_write, bank_terminating
	} bank_state_t;

	typedef enum logic [2:0] {
		dev_init, dev_run, dev_standby, dev_suspend, dev_mode_access
	} dev_state_t;

	// strobe pins are active low: cs, ras, cas, we
	function automatic cmd_t decode_cmd(input logic cs_b, input logic ras_b,
		input logic cas_b, input logic we_b);
		cmd_t c;
		c = cmd_reserved;
		if (cs_b) begin
			c = cmd_inhibit;
		end else begin
			case ({ras_b, cas_b, we_b})
				3'b111: c = cmd_nop;
				3'b011: c = cmd_active;
				3'b101: c = cmd_read;
				3'b100: c = cmd_write;
				3'b001: c = cmd_load_command;
				3'b000: c = cmd_load_mode;
				3'b010: c = cmd_active_terminate;
				3'b110: c = cmd_burst_terminate;
				default: c = cmd_reserved;
			endcase
		end
		return c;
	endfunction
endpackage

/* mem_cmd_if.sv */
`timescale 1ns/1ps
interface mem_cmd_if;
	logic                 cke;
	logic                 cs_b;
	logic                 ras_b;
	logic                 cas_b;
	logic                 we_b;
	logic [1:0]           bank_addr;
	logic [11:0]          addr;
	logic                 reset_protect_pin;
	modport controller (output cke, cs_b, ras_b, cas_b, we_b, bank_addr, addr, reset_protect_pin);
	modport device (input cke, cs_b, ras_b, cas_b, we_b, bank_addr, addr, reset_protect_pin);
endinterface

/* bank_state_command_decoder.sv */
`timescale 1ns/1ps
module bank_state_command_decoder #(
	parameter int INIT_COUNT = bank_cmd_pkg::INIT_CYCLES,
	parameter int RCD        = bank_cmd_pkg::RCD_CYCLES,
	parameter int MRD        = bank_cmd_pkg::MRD_CYCLES,
	parameter int WR_DONE    = bank_cmd_pkg::WRITE_DONE_CYCLES
) (
	input  wire logic                    mclk,
	input  wire logic                    rst_b,
	mem_cmd_if.device                    link,
	input  wire logic                    program_done,
	output logic [3*bank_cmd_pkg::NUM_BANKS-1:0] bank_states,
	output bank_cmd_pkg::dev_state_t     dev_state,
	output bank_cmd_pkg::cmd_t           last_cmd,
	output logic                         cmd_valid,
	output logic                         illegal_cmd,
	output logic [bank_cmd_pkg::BANK_W-1:0] read_bank,
	output logic                         read_prior_row,
	output logic                         burst_active
);
	import bank_cmd_pkg::*;

	// ************
	// pin synchronisers
	// ************
	logic [18:0] pin_s1, pin_s2;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1 <= 19'h78000;
			pin_s2 <= 19'h78000;
		end else begin
			pin_s1 <= {link.cke, link.cs_b, link.ras_b, link.cas_b, link.we_b,
				link.bank_addr, link.addr};
			pin_s2 <= pin_s1;
		end
	end
	logic cke_now, rp_s1, rp_s2, rp_prev;
	logic [BANK_W-1:0] ba;
	logic [ROW_W-1:0]  ad;
	cmd_t cmd;
	assign cke_now = pin_s2[18];
	assign ba      = pin_s2[13:12];
	assign ad      = pin_s2[11:0];
	assign cmd     = decode_cmd(pin_s2[17], pin_s2[16], pin_s2[15], pin_s2[14]); // R05 R06

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rp_s1   <= 1'b0;
			rp_s2   <= 1'b0;
			rp_prev <= 1'b0;
		end else begin
			rp_s1   <= link.reset_protect_pin;
			rp_s2   <= rp_s1;
			rp_prev <= rp_s2;
		end
	end

	// ************
	// device and bank state
	// ************
	bank_state_t bst [NUM_BANKS];
	bank_state_t next_bst [NUM_BANKS];
	logic [15:0] bcnt [NUM_BANKS];
	logic [15:0] next_bcnt [NUM_BANKS];
	dev_state_t next_dev;
	logic [31:0] dcnt, next_dcnt;
	logic cke_prev, next_cke_prev, next_illegal, next_valid, next_prior;
	logic next_burst;
	logic [BANK_W-1:0] next_rbank;
	cmd_t next_last;
	logic any_read, all_idle, run_edge;

	always_comb begin
		any_read = 1'b0;
		all_idle = 1'b1;
		for (int i = 0; i < NUM_BANKS; i++) begin
			if (bst[i] == bank_read) any_read = 1'b1;
			if (bst[i] != bank_idle) all_idle = 1'b0;
		end
	end

	always_comb begin
		next_bst      = bst;
		next_bcnt     = bcnt;
		next_dev      = dev_state;
		next_dcnt     = dcnt;
		next_cke_prev = cke_now;
		next_illegal  = 1'b0;
		next_valid    = 1'b0;
		next_prior    = read_prior_row;
		next_rbank    = read_bank;
		next_burst    = burst_active;
		next_last     = last_cmd;
		run_edge      = 1'b0;
		// timed bank states progress on every unsuspended edge
		if (dev_state != dev_suspend) begin // R24
			for (int i = 0; i < NUM_BANKS; i++) begin
				case (bst[i])
					bank_terminating: next_bst[i] = bank_idle; // R14
					bank_activating: begin
						if (bcnt[i] <= 16'h0001) next_bst[i] = bank_row_active; // R15
						else next_bcnt[i] = bcnt[i] - 16'h0001;
					end
					bank_write: begin
						if (program_done || bcnt[i] <= 16'h0001) next_bst[i] = bank_idle;
						else next_bcnt[i] = bcnt[i] - 16'h0001;
					end
					default: ;
				endcase
			end
		end
		if (rp_s2 && !rp_prev) begin
			next_dev  = dev_init; // R17
			next_dcnt = INIT_COUNT;
			for (int i = 0; i < NUM_BANKS; i++) next_bst[i] = bank_idle;
		end else begin
			case (dev_state)
				dev_init: begin
					if (cmd != cmd_inhibit && cmd != cmd_nop) next_illegal = 1'b1; // R17
					if (dcnt <= 32'h1) next_dev = dev_run;
					else next_dcnt = dcnt - 32'h1;
				end
				dev_mode_access: begin
					if (cmd != cmd_inhibit && cmd != cmd_nop) next_illegal = 1'b1; // R16
					if (dcnt <= 32'h1) next_dev = dev_run;
					else next_dcnt = dcnt - 32'h1;
				end
				dev_standby: begin
					if (cke_now && (cmd == cmd_inhibit || cmd == cmd_nop))
						next_dev = dev_run; // R03
					else if (cke_now) next_illegal = 1'b1; // R22
				end
				dev_suspend: begin
					if (cke_now) next_dev = dev_run; // R04
				end
				dev_run: begin
					if (cke_prev && !cke_now) begin // R01
						if (any_read) next_dev = dev_suspend; // R02
						else if (cmd == cmd_inhibit || cmd == cmd_nop) next_dev = dev_standby;
						else next_illegal = 1'b1;
					end else if (cke_prev && cke_now) begin
						run_edge = 1'b1;
					end
				end
				default: next_dev = dev_run;
			endcase
		end
		if (run_edge) begin
			next_last  = cmd;
			next_valid = (cmd != cmd_inhibit && cmd != cmd_nop); // R07
			case (cmd)
				cmd_active: begin
					if (bst[ba] != bank_idle) next_illegal = 1'b1; // R08 R13
					else begin
						next_bst[ba]  = bank_activating;
						next_bcnt[ba] = 16'(RCD);
					end
				end
				cmd_read: begin
					if (bst[ba] == bank_row_active || bst[ba] == bank_read ||
						bst[ba] == bank_write) begin // R09 R10 R11
						next_prior = (bst[ba] == bank_write); // R12
						if (bst[ba] != bank_write) next_bst[ba] = bank_read;
						next_rbank  = ba;
						next_burst  = 1'b1;
					end else next_illegal = 1'b1;
				end
				cmd_write: begin
					if (bst[ba] == bank_row_active) begin // R09
						next_bst[ba]  = bank_write;
						next_bcnt[ba] = 16'(WR_DONE);
					end else next_illegal = 1'b1;
				end
				cmd_load_command: begin
					if (bst[ba] == bank_activating || bst[ba] == bank_terminating)
						next_illegal = 1'b1; // R13
				end
				cmd_load_mode: begin
					if (!all_idle) next_illegal = 1'b1; // R18
					else begin
						next_dev  = dev_mode_access; // R16
						next_dcnt = MRD;
					end
				end
				cmd_active_terminate: begin
					for (int i = 0; i < NUM_BANKS; i++) begin
						if (ad[TERM_ALL_BIT] || i == int'(ba)) begin // R23
							if (bst[i] == bank_write || bst[i] == bank_activating)
								next_illegal = next_illegal | (i == int'(ba)); // R11 R13
							else if (bst[i] != bank_idle) next_bst[i] = bank_terminating;
						end
					end
					if (ad[TERM_ALL_BIT] || ba == read_bank) next_burst = 1'b0;
				end
				cmd_burst_terminate: begin
					if (burst_active && bst[read_bank] == bank_read) begin
						next_bst[read_bank] = bank_row_active; // R19
						next_burst          = 1'b0;
					end else next_illegal = 1'b1;
				end
				cmd_reserved: next_illegal = 1'b1; // R22
				default: ; // R07
			endcase
			// a refused command is flagged only, never reported as taken
			if (next_illegal) next_valid = 1'b0; // R22
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_BANKS; i++) begin
				bst[i]  <= bank_idle;
				bcnt[i] <= 16'h0000;
			end
			dev_state      <= dev_run;
			dcnt           <= 32'h0;
			cke_prev       <= 1'b1;
			illegal_cmd    <= 1'b0;
			cmd_valid      <= 1'b0;
			read_prior_row <= 1'b0;
			read_bank      <= 2'h0;
			burst_active   <= 1'b0;
			last_cmd       <= cmd_inhibit;
		end else begin
			bst            <= next_bst;
			bcnt           <= next_bcnt;
			dev_state      <= next_dev;
			dcnt           <= next_dcnt;
			cke_prev       <= next_cke_prev;
			illegal_cmd    <= next_illegal;
			cmd_valid      <= next_valid;
			read_prior_row <= next_prior;
			read_bank      <= next_rbank;
			burst_active   <= next_burst;
			last_cmd       <= next_last;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_BANKS; i++) bank_states[3*i +: 3] = bst[i];
	end
endmodule

/* mem_cmd_controller.sv */
`timescale 1ns/1ps
module mem_cmd_controller (
	input  wire logic                       mclk,
	input  wire logic                       rst_b,
	mem_cmd_if.controller                   link,
	input  wire logic                       req_valid,
	input  bank_cmd_pkg::cmd_t              req_cmd,
	input  wire logic [bank_cmd_pkg::BANK_W-1:0] req_bank,
	input  wire logic [bank_cmd_pkg::ROW_W-1:0]  req_addr,
	input  wire logic                       req_cke,
	input  wire logic                       req_rp,
	output logic                            req_ready
);
	import bank_cmd_pkg::*;

	// ************
	// pin drivers
	// ************
	logic [3:0] strobes, next_strobes;
	logic cke, next_cke, rp, next_rp;
	logic [BANK_W-1:0] ba, next_ba;
	logic [ROW_W-1:0]  ad, next_ad;

	// ready held high for every command, no state tracking; caller keeps legality
	assign req_ready = 1'b1; // R22

	always_comb begin
		next_strobes = 4'hF;
		next_cke     = cke;
		next_rp      = req_rp;
		next_ba      = ba;
		next_ad      = ad;
		if (req_valid) begin
			next_cke = req_cke; // R01
			next_ba  = req_bank;
			next_ad  = req_addr;
			case (req_cmd) // R05 R06
				cmd_nop:              next_strobes = 4'h7;
				cmd_active:           next_strobes = 4'h3;
				cmd_read:             next_strobes = 4'h5;
				cmd_write:            next_strobes = 4'h4;
				cmd_load_command:     next_strobes = 4'h1;
				cmd_load_mode:        next_strobes = 4'h0;
				cmd_active_terminate: next_strobes = 4'h2;
				cmd_burst_terminate:  next_strobes = 4'h6;
				default:              next_strobes = 4'hF;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			strobes <= 4'hF;
			cke     <= 1'b1;
			rp      <= 1'b0;
			ba      <= 2'h0;
			ad      <= 12'h000;
		end else begin
			strobes <= next_strobes;
			cke     <= next_cke;
			rp      <= next_rp;
			ba      <= next_ba;
			ad      <= next_ad;
		end
	end

	assign link.cs_b              = strobes[3];
	assign link.ras_b             = strobes[2];
	assign link.cas_b             = strobes[1];
	assign link.we_b              = strobes[0];
	assign link.cke               = cke;
	assign link.bank_addr         = ba;
	assign link.addr              = ad;
	assign link.reset_protect_pin = rp;
endmodule

/* mem_cmd_props.sv */
`timescale 1ns/1ps
// ****
// link and decoder checks
// ****
module mem_cmd_props #(
	parameter int RCD = bank_cmd_pkg::RCD_CYCLES,
	parameter int MRD = bank_cmd_pkg::MRD_CYCLES
) (
	input wire logic                mclk,
	input wire logic                rst_b,
	input wire logic                cke,
	input wire logic                cs_b,
	input wire logic                ras_b,
	input wire logic                cas_b,
	input wire logic                we_b,
	input wire logic [1:0]          bank_addr,
	input wire logic                reset_protect_pin,
	input wire logic [11:0]         bank_states,
	input bank_cmd_pkg::dev_state_t dev_state,
	input bank_cmd_pkg::cmd_t       last_cmd,
	input wire logic                cmd_valid,
	input wire logic                illegal_cmd,
	input wire logic [1:0]          read_bank,
	input wire logic                burst_active
);
	import bank_cmd_pkg::*;
	logic [2:0] b0;
	logic [3:0] acnt, mcnt, next_acnt, next_mcnt;
	assign b0 = bank_states[2:0];
	// cycles spent activating bank 0 and in mode access
	always_comb begin
		next_acnt = (b0 == bank_activating) ? acnt + 4'h1 : 4'h0;
		next_mcnt = (dev_state == dev_mode_access) ? mcnt + 4'h1 : 4'h0;
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			acnt <= 4'h0;
			mcnt <= 4'h0;
		end else begin
			acnt <= next_acnt;
			mcnt <= next_mcnt;
		end
	end
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rst_b);
	AST_VALID_SRC: assert property (cmd_valid |->
		$past(!cs_b && !(ras_b && cas_b && we_b), 3)) else $error("valid without command");
	AST_READ_CODE: assert property (cmd_valid && last_cmd == cmd_read |->
		$past({cs_b, ras_b, cas_b, we_b}, 3) == 4'h5 && read_bank == $past(bank_addr, 3))
		else $error("read decode wrong");
	AST_LCR_CODE: assert property (cmd_valid && last_cmd == cmd_load_command |->
		$past({cs_b, ras_b, cas_b, we_b}, 3) == 4'h1) else $error("load command decode wrong");
	AST_ACT_LEN: assert property (b0 == bank_row_active && $past(b0) == bank_activating
		|-> acnt == RCD) else $error("activation length wrong");
	AST_TERM_ONE: assert property (b0 == bank_terminating |=> b0 == bank_idle)
		else $error("terminate not one cycle");
	AST_STANDBY: assert property ($rose(dev_state == dev_standby)
		|-> $past(cke, 4) && !$past(cke, 3) && !$past(burst_active)) else $error("bad standby");
	AST_SUSPEND: assert property ($rose(dev_state == dev_suspend)
		|-> $past(burst_active) && !$past(cke, 3)) else $error("bad suspend");
	AST_EXIT: assert property ($fell(dev_state == dev_standby)
		|-> dev_state == dev_run && $past(cke, 3)) else $error("bad standby exit");
	AST_MRD: assert property (dev_state != dev_mode_access &&
		$past(dev_state) == dev_mode_access |-> mcnt == MRD && dev_state == dev_run)
		else $error("mode access length wrong");
	AST_INIT: assert property ($rose(reset_protect_pin) |-> ##3 dev_state == dev_init)
		else $error("init not entered");
	AST_ILLEGAL: assert property (illegal_cmd |-> !cmd_valid)
		else $error("illegal command taken");
endmodule

/* test_bank_state_command_decoder.sv */
`timescale 1ns/1ps
module test_bank_state_command_decoder;
	import bank_cmd_pkg::*;
	logic        mclk, rst_b, req_valid, req_cke, req_rp, program_done;
	int          ill_count = 0;
	int          ill_base;
	logic        cmd_valid, illegal_cmd, read_prior_row, burst_active;
	cmd_t        req_cmd, last_cmd;
	dev_state_t  dev_state;
	logic [1:0]  req_bank, read_bank, b, o;
	logic [11:0] req_addr, bank_states;
	logic [7:0]  r;
	int          err_count, samples_checked;
	mem_cmd_if   link ();
	mem_cmd_controller u_mem_cmd_controller (.mclk(mclk), .rst_b(rst_b),
		.link(link.controller), .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
		.req_addr(req_addr), .req_cke(req_cke), .req_rp(req_rp), .req_ready());
	bank_state_command_decoder #(.INIT_COUNT(20))
		u_bank_state_command_decoder (.mclk(mclk), .rst_b(rst_b), .link(link.device),
		.program_done(program_done), .bank_states(bank_states), .dev_state(dev_state),
		.last_cmd(last_cmd), .cmd_valid(cmd_valid), .illegal_cmd(illegal_cmd),
		.read_bank(read_bank), .read_prior_row(read_prior_row), .burst_active(burst_active));
	mem_cmd_props #(.RCD(3), .MRD(2)) u_mem_cmd_props (.mclk(mclk), .rst_b(rst_b),
		.cke(link.cke), .cs_b(link.cs_b), .ras_b(link.ras_b), .cas_b(link.cas_b),
		.we_b(link.we_b), .bank_addr(link.bank_addr), .reset_protect_pin(link.reset_protect_pin),
		.bank_states(bank_states), .dev_state(dev_state), .last_cmd(last_cmd),
		.cmd_valid(cmd_valid), .illegal_cmd(illegal_cmd), .read_bank(read_bank),
		.burst_active(burst_active));
	// ****
	// helpers
	// ****
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic logic [11:0] expst(input logic [1:0] k, input bank_state_t s);
		logic [11:0] e;
		e = 12'h000;
		e[3*k+:3] = s;
		return e;
	endfunction
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// request taken on the second edge, then n edges more
	task automatic issue(input cmd_t c, input logic [1:0] k, input logic [11:0] a, input int n);
		@(posedge mclk);
		req_valid <= 1'b1;
		req_cmd <= c;
		req_bank <= k;
		req_addr <= a;
		@(posedge mclk);
		req_valid <= 1'b0;
		idle(n);
	endtask
	// clock enable reaches the pins only with a request, so send it with a nop
	task automatic set_cke(input logic v);
		@(posedge mclk);
		req_valid <= 1'b1;
		req_cmd <= cmd_nop;
		req_cke <= v;
		@(posedge mclk);
		req_valid <= 1'b0;
		idle(5);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ****
	// stimulus
	// ****
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (illegal_cmd === 1'b1) begin
			ill_count <= ill_count + 1;
		end
	end
	initial begin
		repeat (3000) @(posedge mclk);
		err_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		give_verdict();
	end
	initial begin
		{rst_b, req_valid, req_rp, program_done} = 4'h0;
		ill_base = 0;
		req_cke = 1'b1;
		req_cmd = cmd_nop;
		req_bank = 2'h0;
		req_addr = 12'h000;
		err_count = 0;
		samples_checked = 0;
		r = lfsr(8'h48);
		b = r[1:0] ^ 2'h1;
		o = b + 2'h1;
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		req_rp <= 1'b1;
		idle(6);
		chk(12'(dev_state), 12'(dev_init));
		idle(30);
		chk(12'(dev_state), 12'(dev_run));
		$display("test init done");
		issue(cmd_active, b, {4'h0, r}, 4);
		chk(bank_states, expst(b, bank_activating));
		idle(3);
		chk(bank_states, expst(b, bank_row_active));
		for (int i = 0; i < 16; i++) begin
			r = lfsr(r);
			issue(r[0] ? cmd_nop : cmd_inhibit, r[2:1], {r, r[3:0]}, 0);
		end
		issue(cmd_load_command, o, {4'h0, r}, 0);
		idle(4);
		chk(bank_states, expst(b, bank_row_active));
		$display("test activate done");
		issue(cmd_read, b, 12'h000, 5);
		chk(bank_states, expst(b, bank_read));
		chk(12'(read_bank), 12'(b));
		chk(12'(burst_active), 12'h001);
		set_cke(1'b0);
		chk(12'(dev_state), 12'(dev_suspend));
		set_cke(1'b1);
		chk(12'(dev_state), 12'(dev_run));
		issue(cmd_burst_terminate, o, 12'h000, 5);
		chk(12'(burst_active), 12'h000);
		chk(bank_states, expst(b, bank_row_active));
		issue(cmd_read, b, 12'h000, 1);
		issue(cmd_active_terminate, o, 12'h400, 7);
		chk(bank_states, 12'h000);
		chk(12'(burst_active), 12'h000);
		$display("test read done");
		issue(cmd_load_command, o, {4'h0, r}, 4);
		ill_base = ill_count;
		issue(cmd_load_mode, 2'h0, 12'h000, 4);
		chk(12'(dev_state), 12'(dev_mode_access));
		idle(4);
		chk(12'(dev_state), 12'(dev_run));
		chk(12'(ill_count - ill_base), 12'h000);
		issue(cmd_active, o, 12'h000, 8);
		issue(cmd_load_mode, 2'h0, 12'h000, 5);
		chk(12'(ill_count - ill_base), 12'h001);
		chk(bank_states, expst(o, bank_row_active));
		$display("test mode done");
		issue(cmd_write, o, 12'h000, 5);
		chk(bank_states, expst(o, bank_write));
		issue(cmd_read, o, 12'h000, 5);
		chk(12'(read_prior_row), 12'h001);
		@(posedge mclk);
		program_done <= 1'b1;
		repeat (6) @(posedge mclk);
		program_done <= 1'b0;
		issue(cmd_active_terminate, o, 12'h000, 6);
		chk(bank_states, 12'h000);
		$display("test write done");
		set_cke(1'b0);
		chk(12'(dev_state), 12'(dev_standby));
		set_cke(1'b1);
		chk(12'(dev_state), 12'(dev_run));
		$display("test standby done");
		give_verdict();
	end
endmodule
